// file: hdl/micin_pkg.sv
package micin_pkg;

    // Register addresses (seven-bit register index of the control word).
    localparam logic [6:0] ADDR_POWER_ONE     = 7'h01;
    localparam logic [6:0] ADDR_POWER_TWO     = 7'h02;
    localparam logic [6:0] ADDR_LEVEL_ONE     = 7'h20;
    localparam logic [6:0] ADDR_INPUT_ROUTING = 7'h2c;
    localparam logic [6:0] ADDR_INPUT_GAIN    = 7'h2d;

    localparam int REG_W  = 9;
    localparam int ADDR_W = 7;
    localparam int WORD_W = 16;

    // Field positions.
    localparam int POS_MIC_BIT     = 0;
    localparam int NEG_MIC_BIT     = 1;
    localparam int AUX_AMP_BIT     = 2;
    localparam int AUX_MODE_BIT    = 3;
    localparam int AMP_EN_BIT      = 2;
    localparam int AUX_EN_BIT      = 6;
    localparam int LEVEL_SEL_BIT   = 8;
    localparam int ZC_BIT          = 7;
    localparam int MUTE_BIT        = 6;
    localparam int GAIN_MSB        = 5;
    localparam int GAIN_W          = 6;

    // Reset values.
    localparam logic [8:0] RST_POWER_ONE     = 9'h000;
    localparam logic [8:0] RST_POWER_TWO     = 9'h000;
    localparam logic [8:0] RST_LEVEL_ONE     = 9'h000;
    localparam logic [8:0] RST_INPUT_ROUTING = 9'h002;
    localparam logic [8:0] RST_INPUT_GAIN    = 9'h050;

    // One decoded register write.
    typedef struct packed {
        logic             valid;
        logic [6:0]       addr;
        logic [8:0]       data;
    } micin_wr_t;

    // Switch and gain settings driven into the analogue path.
    typedef struct packed {
        logic             pos_mic_to_amp_sel;
        logic             neg_mic_to_amp_sel;
        logic             aux_to_amp_sel;
        logic             input_amp_enable;
        logic             input_amp_mute;
        logic             aux_amp_enable;
        logic             aux_amp_mode;
        logic             aux_bypass_switch;
        logic             level_control_select;
        logic [5:0]       input_amp_gain_code;
    } micin_ctrl_t;

    typedef enum logic [1:0] {
        SER_IDLE,
        SER_SHIFT,
        SER_DONE
    } micin_ser_state_t;

endpackage : micin_pkg

// file: hdl/micin_path_ctrl.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// (RULE_01) Routing bit 0 picks positive mic pin, else mid-rail, for non-inverting input.
// (RULE_02) Routing bit 1 connects negative mic pin to inverting input; resets set.
// (RULE_03) Routing bit 2 connects aux amplifier output to inverting input.
// (RULE_04) Power-two bit 2 enables the input gain amplifier.
// (RULE_05) Six-bit gain code, 0.75dB steps, resets to 010000 (0dB).
// (RULE_06) One common gain code drives all selected input paths.
// (RULE_07) Gain bit 7 defers new gain to the first zero crossing.
// (RULE_08) Gain bit 6 mutes amplifier and isolates boost stage; resets set.
// (RULE_09) Level-control bit 8 hands gain to the automatic level control.
// (RULE_10) Power-one bit 6 switches the auxiliary amplifier on.
// (RULE_11) Routing bit 3 selects mixer mode, closing the aux bypass switch.
// (RULE_12) Registers written serially; mode pin picks three-wire or two-wire target.
// (RULE_13) Fields hold until rewritten; outputs follow them on the clock.
module micin_path_ctrl #(
    parameter logic [6:0] DEV_ADDR = 7'h1a
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    // Serial control interface
    input  wire logic                 mode_three_wire_i,
    input  wire logic                 sclk_i,
    input  wire logic                 sdin_i,
    input  wire logic                 csb_i,
    output logic                      sdin_oe_o,
    output logic                      sdin_o,
    // Analogue path status
    input  wire logic                 zero_cross_i,
    input  wire logic [5:0]           level_gain_i,
    // Analogue path controls
    output micin_pkg::micin_ctrl_t    ctrl_o,
    output logic [5:0]                applied_gain_o
);

    logic                       sclk_d_reg, sclk_d_next;
    logic                       sdin_d_reg, sdin_d_next;
    logic                       csb_d_reg, csb_d_next;
    logic [15:0]                shift_reg, shift_next;
    logic [4:0]                 cnt_reg, cnt_next;
    logic [1:0]                 byte_idx_reg, byte_idx_next;
    logic                       ack_reg, ack_next;
    micin_pkg::micin_ser_state_t st_reg, st_next;
    micin_pkg::micin_wr_t       wr_reg, wr_next;

    logic [8:0]                 pwr1_reg, pwr1_next;
    logic [8:0]                 pwr2_reg, pwr2_next;
    logic [8:0]                 lvl1_reg, lvl1_next;
    logic [8:0]                 route_reg, route_next;
    logic [8:0]                 gain_reg, gain_next;
    logic                       zc_pend_reg, zc_pend_next;
    logic [5:0]                 active_gain_reg, active_gain_next;
    micin_pkg::micin_ctrl_t     ctrl_reg, ctrl_next;
    logic [5:0]                 applied_reg, applied_next;

    logic                       sclk_rise;
    logic                       start_cond;
    logic                       stop_cond;

    assign sclk_rise  = sclk_i & ~sclk_d_reg;
    assign start_cond = ~mode_three_wire_i & sclk_i & sclk_d_reg & sdin_d_reg & ~sdin_i;
    assign stop_cond  = ~mode_three_wire_i & sclk_i & sclk_d_reg & ~sdin_d_reg & sdin_i;

    // Serial receiver. Three-wire: 16 bits shifted while chip select is low, latched on
    // its rising edge. Two-wire: start, address byte, two data bytes, each acknowledged.
    always_comb begin
        sclk_d_next   = sclk_i;
        sdin_d_next   = sdin_i;
        csb_d_next    = csb_i;
        shift_next    = shift_reg;
        cnt_next      = cnt_reg;
        byte_idx_next = byte_idx_reg;
        ack_next      = ack_reg;
        st_next       = st_reg;
        wr_next       = '0;
        // (RULE_12) mode pin select
        if (mode_three_wire_i) begin
            ack_next = 1'b0;
            if (!csb_i && sclk_rise) begin
                shift_next = {shift_reg[14:0], sdin_i};
            end
            if (csb_i && !csb_d_reg) begin
                wr_next.valid = 1'b1;
                wr_next.addr  = shift_reg[15:9];
                wr_next.data  = shift_reg[8:0];
            end
            st_next = micin_pkg::SER_IDLE;
        end else if (start_cond) begin
            st_next       = micin_pkg::SER_SHIFT;
            cnt_next      = 5'h00;
            byte_idx_next = 2'h0;
            ack_next      = 1'b0;
        end else if (stop_cond) begin
            st_next  = micin_pkg::SER_IDLE;
            ack_next = 1'b0;
        end else begin
            case (st_reg)
                micin_pkg::SER_IDLE: begin
                    ack_next = 1'b0;
                end
                micin_pkg::SER_SHIFT: begin
                    if (sclk_rise) begin
                        if (cnt_reg == 5'h08) begin
                            cnt_next = 5'h00;
                            if (byte_idx_reg == 2'h0 && shift_reg[7:1] != DEV_ADDR) begin
                                st_next = micin_pkg::SER_IDLE;
                            end else if (byte_idx_reg == 2'h2) begin
                                wr_next.valid = 1'b1;
                                wr_next.addr  = shift_reg[15:9];
                                wr_next.data  = shift_reg[8:0];
                                st_next       = micin_pkg::SER_DONE;
                            end
                            byte_idx_next = byte_idx_reg + 2'h1;
                        end else begin
                            shift_next = {shift_reg[14:0], sdin_i};
                            cnt_next   = cnt_reg + 5'h01;
                        end
                    end
                    if (!sclk_i && sclk_d_reg) begin
                        ack_next = (cnt_reg == 5'h08) &&
                                   (byte_idx_reg != 2'h0 || shift_reg[7:1] == DEV_ADDR);
                    end
                end
                micin_pkg::SER_DONE: begin
                    if (!sclk_i && sclk_d_reg) begin
                        ack_next = 1'b0;
                    end
                end
                default: begin
                    st_next = micin_pkg::SER_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sclk_d_reg   <= 1'b0;
            sdin_d_reg   <= 1'b1;
            csb_d_reg    <= 1'b1;
            shift_reg    <= 16'h0000;
            cnt_reg      <= 5'h00;
            byte_idx_reg <= 2'h0;
            ack_reg      <= 1'b0;
            st_reg       <= micin_pkg::SER_IDLE;
            wr_reg       <= '0;
        end else begin
            sclk_d_reg   <= sclk_d_next;
            sdin_d_reg   <= sdin_d_next;
            csb_d_reg    <= csb_d_next;
            shift_reg    <= shift_next;
            cnt_reg      <= cnt_next;
            byte_idx_reg <= byte_idx_next;
            ack_reg      <= ack_next;
            st_reg       <= st_next;
            wr_reg       <= wr_next;
        end
    end

    // Register file; unused bits are stored so that a later readback path can show them.
    always_comb begin
        pwr1_next  = pwr1_reg;
        pwr2_next  = pwr2_reg;
        lvl1_next  = lvl1_reg;
        route_next = route_reg;
        gain_next  = gain_reg;
        // (RULE_13) hold until rewritten
        if (wr_reg.valid) begin
            case (wr_reg.addr)
                micin_pkg::ADDR_POWER_ONE:     pwr1_next  = wr_reg.data;
                micin_pkg::ADDR_POWER_TWO:     pwr2_next  = wr_reg.data;
                micin_pkg::ADDR_LEVEL_ONE:     lvl1_next  = wr_reg.data;
                micin_pkg::ADDR_INPUT_ROUTING: route_next = wr_reg.data;
                micin_pkg::ADDR_INPUT_GAIN:    gain_next  = wr_reg.data;
                default: begin
                end
            endcase
        end
    end

    // Gain application. Zero-cross mode holds the new code until the first crossing,
    // which avoids audible zipper steps; a later write before it simply replaces it.
    always_comb begin
        zc_pend_next     = zc_pend_reg;
        active_gain_next = active_gain_reg;
        if (wr_reg.valid && wr_reg.addr == micin_pkg::ADDR_INPUT_GAIN) begin
            // (RULE_07) immediate or deferred
            if (wr_reg.data[micin_pkg::ZC_BIT]) begin
                zc_pend_next = 1'b1;
            end else begin
                zc_pend_next     = 1'b0;
                active_gain_next = wr_reg.data[5:0];
            end
        end else if (zc_pend_reg && zero_cross_i) begin
            // (RULE_07) apply at crossing
            zc_pend_next     = 1'b0;
            active_gain_next = gain_reg[5:0];
        end else if (!gain_reg[micin_pkg::ZC_BIT]) begin
            zc_pend_next     = 1'b0;
            active_gain_next = gain_reg[5:0];
        end
    end

    always_comb begin
        ctrl_next = '0;
        // (RULE_01) positive input source
        ctrl_next.pos_mic_to_amp_sel   = route_reg[micin_pkg::POS_MIC_BIT];
        // (RULE_02) negative mic switch
        ctrl_next.neg_mic_to_amp_sel   = route_reg[micin_pkg::NEG_MIC_BIT];
        // (RULE_03) aux to inverting input
        ctrl_next.aux_to_amp_sel       = route_reg[micin_pkg::AUX_AMP_BIT];
        // (RULE_04) amplifier enable
        ctrl_next.input_amp_enable     = pwr2_reg[micin_pkg::AMP_EN_BIT];
        // (RULE_08) mute and isolate
        ctrl_next.input_amp_mute       = gain_reg[micin_pkg::MUTE_BIT];
        // (RULE_10) aux amplifier power
        ctrl_next.aux_amp_enable       = pwr1_reg[micin_pkg::AUX_EN_BIT];
        // (RULE_11) buffer or mixer mode
        ctrl_next.aux_amp_mode         = route_reg[micin_pkg::AUX_MODE_BIT];
        ctrl_next.aux_bypass_switch    = route_reg[micin_pkg::AUX_MODE_BIT];
        // (RULE_09) level control owns gain
        ctrl_next.level_control_select = lvl1_reg[micin_pkg::LEVEL_SEL_BIT];
        // (RULE_05) stored gain code
        ctrl_next.input_amp_gain_code  = gain_reg[5:0];
        // (RULE_06) one common gain
        applied_next = lvl1_reg[micin_pkg::LEVEL_SEL_BIT] ? level_gain_i : active_gain_reg;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            pwr1_reg        <= micin_pkg::RST_POWER_ONE;
            pwr2_reg        <= micin_pkg::RST_POWER_TWO;
            lvl1_reg        <= micin_pkg::RST_LEVEL_ONE;
            route_reg       <= micin_pkg::RST_INPUT_ROUTING;
            gain_reg        <= micin_pkg::RST_INPUT_GAIN;
            zc_pend_reg     <= 1'b0;
            active_gain_reg <= micin_pkg::RST_INPUT_GAIN[5:0];
            ctrl_reg        <= '0;
            applied_reg     <= micin_pkg::RST_INPUT_GAIN[5:0];
            sdin_oe_o       <= 1'b0;
            sdin_o          <= 1'b0;
        end else begin
            pwr1_reg        <= pwr1_next;
            pwr2_reg        <= pwr2_next;
            lvl1_reg        <= lvl1_next;
            route_reg       <= route_next;
            gain_reg        <= gain_next;
            zc_pend_reg     <= zc_pend_next;
            active_gain_reg <= active_gain_next;
            ctrl_reg        <= ctrl_next;
            applied_reg     <= applied_next;
            sdin_oe_o       <= ack_next;
            sdin_o          <= 1'b0;
        end
    end

    assign ctrl_o         = ctrl_reg;
    assign applied_gain_o = applied_reg;

endmodule : micin_path_ctrl

`default_nettype wire

// file: dv/micin_path_properties.sv
`timescale 1ns/100ps
`default_nettype none
module micin_path_properties (
    // Clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    // Watched ports
    input  wire logic                   mode_three_wire_i,
    input  wire logic                   sclk_i,
    input  wire logic                   csb_i,
    input  wire logic                   sdin_oe_o,
    input  wire logic                   sdin_o,
    input  wire logic [5:0]             level_gain_i,
    input  wire micin_pkg::micin_ctrl_t ctrl_o,
    input  wire logic [5:0]             applied_gain_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    reset_fields_a: assert property ($fell(sys_rst_i) |=> ctrl_o == 15'h2410)
        else $error("fields after reset are wrong");
    bypass_mirror_a: assert property (ctrl_o.aux_bypass_switch == ctrl_o.aux_amp_mode)
        else $error("bypass switch differs from aux mode");
    level_gain_a: assert property (ctrl_o.level_control_select &&
        $past(ctrl_o.level_control_select) |-> applied_gain_o == $past(level_gain_i))
        else $error("applied gain ignores level control");
    gain_follow_a: assert property ($changed(applied_gain_o) &&
        !ctrl_o.level_control_select && !$past(ctrl_o.level_control_select)
        |-> applied_gain_o == ctrl_o.input_amp_gain_code)
        else $error("applied gain differs from stored code");
    ack_level_a: assert property (sdin_o == 1'b0)
        else $error("data line driven high");
    ack_mode_a: assert property (sdin_oe_o |-> !$past(mode_three_wire_i))
        else $error("acknowledge in three-wire mode");
    ack_phase_a: assert property ($changed(sdin_oe_o) |-> !sclk_i)
        else $error("acknowledge moved while clock high");
    field_hold_a: assert property (mode_three_wire_i && $changed(ctrl_o) &&
        !$past(sys_rst_i, 2) |-> $past(csb_i) && $past(csb_i, 2))
        else $error("fields changed inside a frame");
    cover property ($rose(sdin_oe_o));
    cover property ($changed(applied_gain_o) && !$changed(ctrl_o));
    cover property (ctrl_o.level_control_select);
endmodule : micin_path_properties
`default_nettype wire

// file: dv/micin_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module micin_host_model (
    // Clock and resolved data line
    input  wire logic clk_i,
    input  wire logic line_i,
    // Serial lines driven by the host
    output logic      sclk_o,
    output logic      sdin_o,
    output logic      csb_o
);
    initial begin
        sclk_o = 1'b1;
        sdin_o = 1'b1;
        csb_o  = 1'b1;
    end
    // Six clocks a phase leave room for the device's input synchroniser.
    task automatic step(input logic c, input logic d);
        repeat (6) @(posedge clk_i);
        sclk_o <= c;
        sdin_o <= d;
    endtask : step
    task automatic write3(input logic [15:0] w);
        @(posedge clk_i);
        csb_o <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            step(1'b0, w[i]);
            step(1'b1, w[i]);
        end
        repeat (6) @(posedge clk_i);
        csb_o  <= 1'b1;
        sdin_o <= ~w[0];
    endtask : write3
    task automatic write2(input logic [7:0] dev, input logic [15:0] w, output int acks);
        logic [7:0] b;
        acks = 0;
        step(1'b1, 1'b1);
        step(1'b1, 1'b0);
        for (int k = 0; k < 3; k++) begin
            b = (k == 0) ? dev : ((k == 1) ? w[15:8] : w[7:0]);
            for (int i = 7; i >= 0; i--) begin
                step(1'b0, b[i]);
                step(1'b1, b[i]);
            end
            step(1'b0, 1'b1);
            step(1'b1, 1'b1);
            if (line_i === 1'b0) begin
                acks++;
            end
        end
        step(1'b0, 1'b0);
        step(1'b1, 1'b0);
        step(1'b1, 1'b1);
    endtask : write2
endmodule : micin_host_model
`default_nettype wire

// file: dv/tb_mic_input_path_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_mic_input_path_control;
    localparam logic [6:0] DEV = 7'h1a;
    logic                  clk_i = 1'b0;
    logic                  sys_rst_i = 1'b1;
    logic                  mode_i = 1'b1;
    logic                  zc_i = 1'b0;
    logic [5:0]            lg_i = 6'h2a;
    logic                  sclk, sdin_h, csb, oe, sdo;
    wire logic             line;
    micin_pkg::micin_ctrl_t ctrl;
    logic [5:0]            gain;
    logic [8:0]            e1, e2, e32, e44, e45;
    int                    fail_count = 0;
    int                    total_checks = 0;
    int                    acks;
    assign line = oe ? sdo : sdin_h;
    always #4 clk_i = ~clk_i;
    micin_path_ctrl #(.DEV_ADDR(DEV)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .mode_three_wire_i(mode_i), .sclk_i(sclk), .sdin_i(line), .csb_i(csb),
        .sdin_oe_o(oe), .sdin_o(sdo), .zero_cross_i(zc_i), .level_gain_i(lg_i),
        .ctrl_o(ctrl), .applied_gain_o(gain));
    micin_host_model host_u (.clk_i(clk_i), .line_i(line), .sclk_o(sclk), .sdin_o(sdin_h),
        .csb_o(csb));
    function automatic micin_pkg::micin_ctrl_t exp_ctrl();
        return {e44[0], e44[1], e44[2], e2[2], e45[6], e1[6], e44[3], e44[3], e32[8], e45[5:0]};
    endfunction : exp_ctrl
    task automatic chk_ctrl(input micin_pkg::micin_ctrl_t e);
        total_checks++;
        if (ctrl !== e) begin
            fail_count++;
            $display("FAIL %0t got %h exp %h", $time, ctrl, e);
        end
    endtask : chk_ctrl
    task automatic chk_val(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL %0t got %h exp %h", $time, g, e);
        end
    endtask : chk_val
    task automatic upd(input logic [6:0] a, input logic [8:0] d);
        case (a)
            7'h01: e1 = d;
            7'h02: e2 = d;
            7'h20: e32 = d;
            7'h2c: e44 = d;
            7'h2d: e45 = d;
            default: ;
        endcase
    endtask : upd
    task automatic put(input logic [6:0] a, input logic [8:0] d);
        upd(a, d);
        host_u.write3({a, d});
        repeat (4) @(posedge clk_i);
    endtask : put
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        $display("FAIL %0t got %h exp %h", $time, 1'b0, 1'b1);
        wrap_up();
    end
    initial begin
        {e1, e2, e32, e44, e45} = {9'h000, 9'h000, 9'h000, 9'h002, 9'h050};
        repeat (6) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk_ctrl(exp_ctrl());
        chk_val({2'b00, gain}, 8'h10);
        $display("test reset values done");
        put(7'h2c, 9'h00d);
        put(7'h02, 9'h004);
        put(7'h01, 9'h040);
        put(7'h2d, 9'h03f);
        chk_ctrl(exp_ctrl());
        chk_val({2'b00, gain}, 8'h3f);
        put(7'h7f, 9'h1ff);
        chk_ctrl(exp_ctrl());
        $display("test three-wire writes done");
        put(7'h2d, 9'h080);
        chk_ctrl(exp_ctrl());
        chk_val({2'b00, gain}, 8'h3f);
        zc_i <= 1'b1;
        @(posedge clk_i);
        zc_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk_val({2'b00, gain}, 8'h00);
        $display("test zero-cross update done");
        mode_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        upd(7'h20, 9'h100);
        host_u.write2({DEV, 1'b0}, {7'h20, 9'h100}, acks);
        repeat (4) @(posedge clk_i);
        chk_val(acks[7:0], 8'h03);
        chk_ctrl(exp_ctrl());
        chk_val({2'b00, gain}, 8'h2a);
        lg_i <= 6'h15;
        repeat (3) @(posedge clk_i);
        chk_val({2'b00, gain}, 8'h15);
        host_u.write2({~DEV, 1'b0}, {7'h20, 9'h000}, acks);
        repeat (4) @(posedge clk_i);
        chk_val(acks[7:0], 8'h00);
        chk_ctrl(exp_ctrl());
        $display("test two-wire writes done");
        wrap_up();
    end
endmodule : tb_mic_input_path_control
bind micin_path_ctrl micin_path_properties chk_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .mode_three_wire_i(mode_three_wire_i), .sclk_i(sclk_i), .csb_i(csb_i),
    .sdin_oe_o(sdin_oe_o), .sdin_o(sdin_o), .level_gain_i(level_gain_i), .ctrl_o(ctrl_o),
    .applied_gain_o(applied_gain_o));
`default_nettype wire
